// File: rtl/pirqe_consts.svh
// Register offsets, field positions and reset values of the interrupt enable block
`ifndef PIRQE_CONSTS_SVH
`define PIRQE_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PIRQE_OFS_ENABLE   12'h000
`define PIRQE_OFS_FLAGS    12'h004
`define PIRQE_OFS_GATED    12'h008
`define PIRQE_OFS_STATUS   12'h00C
`define PIRQE_OFS_MASK     12'h010

// ----------------------------------------
// Enable register fields
// ----------------------------------------
`define PIRQE_BIT_RSVD     7
`define PIRQE_BIT_CMP2     6
`define PIRQE_BIT_CMP1     5
`define PIRQE_BIT_CMP0     4
`define PIRQE_BIT_PCA      3
`define PIRQE_BIT_WIN      2
`define PIRQE_BIT_SMB      1
`define PIRQE_BIT_SPI      0
`define PIRQE_WMASK        8'h7F

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PIRQE_RST_ENABLE   8'h00
`define PIRQE_RST_STATUS   8'h00
`define PIRQE_RST_MASK     8'h00

`endif

// File: rtl/pirqe_pkg.sv
// Types shared by the interrupt enable block
package pirqe_pkg;
	// ----------------------------------------
	// Captured AHB address phase
	// ----------------------------------------
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [11:0] addr;
	} pirqe_aphase_t;

	// ----------------------------------------
	// Source flags, one bit per enable field
	// ----------------------------------------
	typedef struct packed {
		logic cmp2;
		logic cmp1;
		logic cmp0;
		logic pca;
		logic win;
		logic smb;
		logic spi;
	} pirqe_src_t;
endpackage

// File: rtl/pirqe_top.sv
// Peripheral interrupt enable register with AHB-Lite access and gated requests
// Functional notes
// - Bit 6 passes the comparator-2 flag to the core when one and blocks it when zero.
// - Bit 5 passes the comparator-1 flag when set and suppresses it when cleared.
// - Bit 4 passes the comparator-0 flag when set and suppresses it when cleared.
// - Bit 3 masks or passes all counter-array sources together.
// - Bit 2 passes or blocks the converter window-compare request.
// - Bit 1 passes or blocks all management-bus requests.
`timescale 1ns/1ps
`include "pirqe_consts.svh"
`default_nettype none

module pirqe_top
	import pirqe_pkg::*;
#(
	parameter int PCA_SRC_W = 6
) (
	// Clock and reset
	input  wire logic                 clock_in,
	input  wire logic                 arst_n_in,
	// AHB-Lite slave
	input  wire logic                 hsel_in,
	input  wire logic [11:0]          haddr_in,
	input  wire logic [1:0]           htrans_in,
	input  wire logic                 hwrite_in,
	input  wire logic [2:0]           hsize_in,
	input  wire logic                 hready_in,
	input  wire logic [31:0]          hwdata_in,
	output logic      [31:0]          hrdata_out,
	output logic                      hreadyout_out,
	output logic                      hresp_out,
	// Source flags
	input  wire logic                 comparator_two_irq_flag_in,
	input  wire logic                 comparator_one_irq_flag_in,
	input  wire logic                 comparator_zero_irq_flag_in,
	input  wire logic [PCA_SRC_W-1:0] programmable_counter_array_flags_in,
	input  wire logic                 main_converter_window_flag_in,
	input  wire logic                 mgmt_bus_irq_flag_in,
	input  wire logic                 spi_irq_flag_in,
	// Gated requests to the core
	output logic                      comparator_two_req_out,
	output logic                      comparator_one_req_out,
	output logic                      comparator_zero_req_out,
	output logic [PCA_SRC_W-1:0]      programmable_counter_array_req_out,
	output logic                      main_converter_window_req_out,
	output logic                      mgmt_bus_req_out,
	output logic                      spi_req_out,
	// Summary interrupt
	output logic                      irq_out
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0]    peripheral_irq_enable_one_q;
	logic [7:0]    status_q;
	logic [7:0]    mask_q;
	logic [7:0]    status_d;
	logic [7:0]    enable_d;
	logic [7:0]    mask_d;
	pirqe_aphase_t aph_q;
	pirqe_src_t    src;
	pirqe_src_t    src_prev_q;
	logic [7:0]    rise;
	logic [31:0]   rdata_d;
	logic          rd_en;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] pad8(input logic [7:0] v);
		return {24'h000000, v};
	endfunction

	// Write strobe of one register, taken in the data phase
	function automatic logic wr_hit(input pirqe_aphase_t a, input logic [11:0] ofs);
		return a.valid & a.write & (a.addr == ofs);
	endfunction

	// One request line: source flag gated by its enable bit
	function automatic logic gate(input logic flag, input logic en);
		return flag & en;
	endfunction

	// ----------------------------------------
	// Source flags
	// ----------------------------------------
	// Counter-array sources share one enable, so one summary bit
	assign src.cmp2 = comparator_two_irq_flag_in;
	assign src.cmp1 = comparator_one_irq_flag_in;
	assign src.cmp0 = comparator_zero_irq_flag_in;
	assign src.pca  = |programmable_counter_array_flags_in;
	assign src.win  = main_converter_window_flag_in;
	assign src.smb  = mgmt_bus_irq_flag_in;
	assign src.spi  = spi_irq_flag_in;

	// ----------------------------------------
	// Bus slave: zero wait states, always OKAY
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			aph_q <= '0;
		end else if (hready_in) begin
			aph_q.valid <= hsel_in & htrans_in[1];
			aph_q.write <= hwrite_in;
			aph_q.addr  <= haddr_in;
		end
	end

	assign rd_en = hsel_in & htrans_in[1] & ~hwrite_in & hready_in;

	// Never stalls, so the master needs no wait logic
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			hreadyout_out <= 1'b1;
		end else begin
			hreadyout_out <= 1'b1;
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			hresp_out <= 1'b0;
		end else begin
			hresp_out <= 1'b0;
		end
	end

	// ----------------------------------------
	// Enable register
	// ----------------------------------------
	// Reserved bit never stored, so it reads zero
	always_comb begin
		enable_d = peripheral_irq_enable_one_q;
		if (wr_hit(aph_q, `PIRQE_OFS_ENABLE)) begin
			enable_d = hwdata_in[7:0] & `PIRQE_WMASK;
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			peripheral_irq_enable_one_q <= `PIRQE_RST_ENABLE;
		end else begin
			peripheral_irq_enable_one_q <= enable_d;
		end
	end

	// ----------------------------------------
	// Mask register
	// ----------------------------------------
	always_comb begin
		mask_d = mask_q;
		if (wr_hit(aph_q, `PIRQE_OFS_MASK)) begin
			mask_d = hwdata_in[7:0] & `PIRQE_WMASK;
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mask_q <= `PIRQE_RST_MASK;
		end else begin
			mask_q <= mask_d;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Next-state values, so a read right behind a write sees the new word
	always_comb begin
		rdata_d = 32'h00000000;
		unique case (haddr_in)
			`PIRQE_OFS_ENABLE: rdata_d = pad8(enable_d);
			`PIRQE_OFS_FLAGS:  rdata_d = pad8({1'b0, src});
			`PIRQE_OFS_GATED:  rdata_d = pad8({1'b0, src} & enable_d);
			`PIRQE_OFS_STATUS: rdata_d = pad8(status_d);
			`PIRQE_OFS_MASK:   rdata_d = pad8(mask_d);
			default:           rdata_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			hrdata_out <= 32'h00000000;
		end else if (rd_en) begin
			hrdata_out <= rdata_d;
		end
	end

	// ----------------------------------------
	// Gated requests
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			comparator_two_req_out <= 1'b0;
		end else begin
			comparator_two_req_out <= gate(src.cmp2,
				peripheral_irq_enable_one_q[`PIRQE_BIT_CMP2]);
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			comparator_one_req_out <= 1'b0;
		end else begin
			comparator_one_req_out <= gate(src.cmp1,
				peripheral_irq_enable_one_q[`PIRQE_BIT_CMP1]);
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			comparator_zero_req_out <= 1'b0;
		end else begin
			comparator_zero_req_out <= gate(src.cmp0,
				peripheral_irq_enable_one_q[`PIRQE_BIT_CMP0]);
		end
	end

	// All counter-array sources share one enable bit
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			programmable_counter_array_req_out <= '0;
		end else begin
			programmable_counter_array_req_out <= programmable_counter_array_flags_in
				& {PCA_SRC_W{peripheral_irq_enable_one_q[`PIRQE_BIT_PCA]}};
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			main_converter_window_req_out <= 1'b0;
		end else begin
			main_converter_window_req_out <= gate(src.win,
				peripheral_irq_enable_one_q[`PIRQE_BIT_WIN]);
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mgmt_bus_req_out <= 1'b0;
		end else begin
			mgmt_bus_req_out <= gate(src.smb,
				peripheral_irq_enable_one_q[`PIRQE_BIT_SMB]);
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			spi_req_out <= 1'b0;
		end else begin
			spi_req_out <= gate(src.spi,
				peripheral_irq_enable_one_q[`PIRQE_BIT_SPI]);
		end
	end

	// ----------------------------------------
	// Sticky status on rising source flag while its enable bit is set
	// ----------------------------------------
	// Set beats write-one-to-clear, so no edge is lost
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			src_prev_q <= '0;
		end else begin
			src_prev_q <= src;
		end
	end

	assign rise = {1'b0, src & ~src_prev_q} & peripheral_irq_enable_one_q;

	always_comb begin
		status_d = status_q;
		if (wr_hit(aph_q, `PIRQE_OFS_STATUS)) begin
			status_d = status_q & ~hwdata_in[7:0];
		end
		status_d = (status_d | rise) & `PIRQE_WMASK;
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			status_q <= `PIRQE_RST_STATUS;
		end else begin
			status_q <= status_d;
		end
	end

	// ----------------------------------------
	// Summary interrupt
	// ----------------------------------------
	// Built from next-state values, so it tracks status and mask exactly
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(status_d & mask_d);
		end
	end

endmodule

`default_nettype wire

// File: verification/pirqe_core_model.sv
// Core-side model latching the gated requests it receives
`timescale 1ns/1ps
`default_nettype none
module pirqe_core_model
	import pirqe_pkg::*;
(
	// Clock, reset, clear and requests
	input  wire logic       clock_in,
	input  wire logic       arst_n_in,
	input  wire logic       clear_in,
	input  wire pirqe_src_t req_in,
	output var  pirqe_src_t taken_out
);
	// Sticky, so a short request is never missed unless it comes while clear_in is high
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in)
			taken_out <= 7'h00;
		else if (clear_in)
			taken_out <= 7'h00;
		else
			taken_out <= taken_out | req_in;
	end
endmodule
`default_nettype wire

// File: verification/pirqe_top_bench.sv
// Self-checking bench of the interrupt enable block
`timescale 1ns/1ps
`include "pirqe_consts.svh"
`default_nettype none
module pirqe_top_bench;
	import pirqe_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, hw = 1'b0, clr = 1'b0, hro, irq;
	logic [1:0]  ht = 2'h0;
	logic [11:0] ha = 12'h000;
	logic [31:0] wd = 32'h0, rd, hrd;
	logic [6:0]  fl = 7'h00;
	logic [5:0]  pf = 6'h00;
	logic [7:0]  e;
	wire logic [11:0] rq;
	wire pirqe_src_t rs = {rq[11:9], |rq[8:3], rq[2:0]};
	pirqe_src_t  tk;
	int          bad_count = 0, total_checks = 0, cyc = 0, k;
	pirqe_top DUT (.clock_in(clk), .arst_n_in(rst_n), .hsel_in(1'b1), .haddr_in(ha),
		.htrans_in(ht), .hwrite_in(hw), .hsize_in(3'h2), .hready_in(hro), .hwdata_in(wd),
		.hrdata_out(hrd), .hreadyout_out(hro), .hresp_out(), .comparator_two_irq_flag_in(fl[6]),
		.comparator_one_irq_flag_in(fl[5]), .comparator_zero_irq_flag_in(fl[4]),
		.programmable_counter_array_flags_in(pf), .main_converter_window_flag_in(fl[2]),
		.mgmt_bus_irq_flag_in(fl[1]), .spi_irq_flag_in(fl[0]), .comparator_two_req_out(rq[11]),
		.comparator_one_req_out(rq[10]), .comparator_zero_req_out(rq[9]),
		.programmable_counter_array_req_out(rq[8:3]), .main_converter_window_req_out(rq[2]),
		.mgmt_bus_req_out(rq[1]), .spi_req_out(rq[0]), .irq_out(irq));
	pirqe_core_model core (.clock_in(clk), .arst_n_in(rst_n), .clear_in(clr), .req_in(rs),
		.taken_out(tk));
	initial forever #5 clk = ~clk;
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", n, x, g);
		end
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		ha <= a;
		ht <= 2'h2;
		hw <= w;
		do @(posedge clk); while (hro !== 1'b1);
		ht <= 2'h0;
		wd <= d;
		do @(posedge clk); while (hro !== 1'b1);
		rd = hrd;
	endtask
	task wirq(input logic [11:0] a, input logic [31:0] d, input logic x);
		bus(1'b1, a, d);
		repeat (3) @(posedge clk);
		chk("irq", {31'h0, x}, {31'h0, irq});
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Budget far above the roughly 170 cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			give_verdict();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		for (k = 0; k < 20; k += 4) begin
			bus(1'b0, 12'(k), 32'h0);
			chk("reset", 32'h0, rd);
		end
		bus(1'b1, 12'h020, 32'hFF);
		bus(1'b0, 12'h020, 32'h0);
		chk("unmapped", 32'h0, rd);
		fl <= 7'h7F;
		pf <= 6'h2D;
		for (k = 0; k < 8; k++) begin
			e = (k == 7) ? 8'hFF : 8'h01 << k;
			bus(1'b1, `PIRQE_OFS_ENABLE, {24'h0, e});
			clr <= 1'b1;
			@(posedge clk);
			clr <= 1'b0;
			repeat (2) @(posedge clk);
			chk("req", {20'h0, e[6:4], 6'h2D & {6{e[3]}}, e[2:0]}, {20'h0, rq});
			chk("core", {25'h0, e[6:0]}, {25'h0, tk});
			bus(1'b0, `PIRQE_OFS_ENABLE, 32'h0);
			chk("enable", {25'h0, e[6:0]}, rd);
			bus(1'b0, `PIRQE_OFS_GATED, 32'h0);
			chk("gated", {25'h0, e[6:0]}, rd);
		end
		bus(1'b0, `PIRQE_OFS_FLAGS, 32'h0);
		chk("flags", 32'h7F, rd);
		fl <= 7'h00;
		bus(1'b1, `PIRQE_OFS_ENABLE, 32'h40);
		bus(1'b1, `PIRQE_OFS_STATUS, 32'h7F);
		bus(1'b1, `PIRQE_OFS_MASK, 32'h40);
		fl <= 7'h40;
		repeat (3) @(posedge clk);
		bus(1'b0, `PIRQE_OFS_STATUS, 32'h0);
		chk("status", 32'h40, rd);
		wirq(`PIRQE_OFS_MASK, 32'h00, 1'b0);
		wirq(`PIRQE_OFS_MASK, 32'h40, 1'b1);
		wirq(`PIRQE_OFS_STATUS, 32'h40, 1'b0);
		bus(1'b1, `PIRQE_OFS_ENABLE, 32'h7F);
		repeat (2) @(posedge clk);
		chk("pre-reset req", {20'h0, 3'h4, 6'h2D, 3'h0}, {20'h0, rq});
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk("reset outputs", 32'h0, {19'h0, irq, rq});
		rst_n <= 1'b1;
		bus(1'b0, `PIRQE_OFS_ENABLE, 32'h0);
		chk("reset enable", 32'h0, rd);
		give_verdict();
	end
endmodule
bind pirqe_top pirqe_top_sva #(.PCA_SRC_W(PCA_SRC_W)) u_sva (.clock_in, .arst_n_in,
	.hrdata_out, .comparator_two_irq_flag_in, .comparator_one_irq_flag_in,
	.comparator_zero_irq_flag_in, .programmable_counter_array_flags_in,
	.main_converter_window_flag_in, .mgmt_bus_irq_flag_in, .comparator_two_req_out,
	.comparator_one_req_out, .comparator_zero_req_out, .programmable_counter_array_req_out,
	.main_converter_window_req_out, .mgmt_bus_req_out, .hreadyout_out, .hresp_out);
`default_nettype wire

// File: verification/pirqe_top_sva.sv
// Port-level checks of the interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module pirqe_top_sva #(
	parameter int PCA_SRC_W = 6
) (
	// Clock, reset and read data
	input wire logic                 clock_in,
	input wire logic                 arst_n_in,
	input wire logic [31:0]          hrdata_out,
	// Source flags
	input wire logic                 comparator_two_irq_flag_in,
	input wire logic                 comparator_one_irq_flag_in,
	input wire logic                 comparator_zero_irq_flag_in,
	input wire logic [PCA_SRC_W-1:0] programmable_counter_array_flags_in,
	input wire logic                 main_converter_window_flag_in,
	input wire logic                 mgmt_bus_irq_flag_in,
	// Gated requests
	input wire logic                 comparator_two_req_out,
	input wire logic                 comparator_one_req_out,
	input wire logic                 comparator_zero_req_out,
	input wire logic [PCA_SRC_W-1:0] programmable_counter_array_req_out,
	input wire logic                 main_converter_window_req_out,
	input wire logic                 mgmt_bus_req_out,
	// Bus response
	input wire logic                 hreadyout_out,
	input wire logic                 hresp_out
);
	// Single-bit sources other than SPI packed so the checks stay short
	wire logic [4:0] rq = {comparator_two_req_out, comparator_one_req_out,
		comparator_zero_req_out, main_converter_window_req_out, mgmt_bus_req_out};
	wire logic [4:0] fl = {comparator_two_irq_flag_in, comparator_one_irq_flag_in,
		comparator_zero_irq_flag_in, main_converter_window_flag_in, mgmt_bus_irq_flag_in};
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!arst_n_in);
	property p_rsvd; hrdata_out[31:7] == 25'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
	property p_c2; rq[4] |-> $past(fl[4]); endproperty
	a_c2: assert property (p_c2) else $error("c2 req w/o flag");
	property p_c1; rq[3] |-> $past(fl[3]); endproperty
	a_c1: assert property (p_c1) else $error("c1 req w/o flag");
	property p_c0; rq[2] |-> $past(fl[2]); endproperty
	a_c0: assert property (p_c0) else $error("c0 req w/o flag");
	property p_win; rq[1] |-> $past(fl[1]); endproperty
	a_win: assert property (p_win) else $error("win req w/o flag");
	property p_smb; rq[0] |-> $past(fl[0]); endproperty
	a_smb: assert property (p_smb) else $error("smb req w/o flag");
	property p_pca; |programmable_counter_array_req_out |->
		programmable_counter_array_req_out == $past(programmable_counter_array_flags_in); endproperty
	a_pca: assert property (p_pca) else $error("pca sources split");
	property p_pcaf; $rose(|programmable_counter_array_req_out) |-> $past(|programmable_counter_array_flags_in); endproperty
	a_pcaf: assert property (p_pcaf) else $error("pca req w/o flag");
	property p_okay; hreadyout_out && !hresp_out; endproperty
	a_okay: assert property (p_okay) else $error("bus answer not ready and okay");
endmodule
`default_nettype wire
